// *** verilog/ring_pkg.sv ***
package ring_pkg;

    // ****************************************************************
    // register map (word index, byte address is four times the index)
    // ****************************************************************
    localparam int ADR_W = 8;
    localparam int IDX_W = 6;
    localparam logic [IDX_W-1:0] IDX_CTRL_A = 6'h16;
    localparam logic [IDX_W-1:0] IDX_CTRL_B = 6'h17;
    localparam logic [IDX_W-1:0] IDX_CTRL_C = 6'h18;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h19;

    localparam logic [7:0] RST_CTRL_A = 8'h96;
    localparam logic [7:0] RST_CTRL_B = 8'h2d;
    localparam logic [7:0] RST_CTRL_C = 8'h19;

    // ****************************************************************
    // field layouts
    // ****************************************************************
    typedef struct packed {
        logic [1:0] delay_lo;
        logic [5:0] max_ring_freq_limit;
    } ctrl_a_t;

    typedef struct packed {
        logic delay_hi;
        logic [3:0] spare;
        logic [2:0] ring_confirm_interval;
    } ctrl_b_t;

    typedef struct packed {
        logic ring_validation_enable;
        logic spare;
        logic [5:0] assert_time;
    } ctrl_c_t;

    typedef struct packed {
        logic [4:0] spare;
        logic too_low;
        logic too_high;
        logic ring_valid;
    } status_t;

    typedef enum logic [1:0] {ST_IDLE, ST_QUALIFY, ST_DELAY, ST_VALID} state_t;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ = 50;
    localparam int TICK_STEP_US = 2000;
    localparam int TICK_CYCLES = TICK_STEP_US * CLK_MHZ;
    localparam int DELAY_STEP_MS = 256;
    localparam int DELAY_STEP_TICKS = DELAY_STEP_MS * 1000 / TICK_STEP_US;
    localparam int PHASE_W = 10;
    localparam int CONFIRM_MS [8] = '{100, 150, 200, 256, 384, 512, 640, 1024};

    function automatic logic [PHASE_W-1:0] confirm_ticks(input logic [2:0] code);
        confirm_ticks = PHASE_W'(CONFIRM_MS[code] * 1000 / TICK_STEP_US);
    endfunction

    function automatic logic [PHASE_W-1:0] delay_ticks(input logic [2:0] code);
        delay_ticks = PHASE_W'(int'(code) * DELAY_STEP_TICKS);
    endfunction

endpackage

// *** verilog/ring_tick_gen.sv ***
`timescale 1ns/1ps
module ring_tick_gen #(
    parameter int DIV = 100000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic tick_o
);
    localparam int CNT_W = $clog2(DIV);

    logic [CNT_W-1:0] cnt_q;
    logic tick_q;

    generate
        // a two-cycle tick would leave only one idle cycle between pulses
        if (DIV < 3) begin : g_bad_div
            $error("tick divider must be at least 3");
        end
    endgenerate

    // common timebase for every timer
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q == CNT_W'(DIV - 1)) begin
            cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
            tick_q <= 1'b0;
        end
    end

    assign tick_o = tick_q;

endmodule

// *** verilog/ring_frequency_validator.sv ***
`timescale 1ns/1ps
// Contract
// - control word: bits 7:6 low delay bits, 5:0 frequency limit, reset 10010110.
// - after validation wait 0, 256, 512 ... 1792 ms by three-bit delay code.
// - countdown timer loads assertion value on each line event, decrements steadily.
// - on next event, remaining count above limit rejects ring as too fast.
// - assertion value minus limit sets shortest event spacing in 2.0 ms steps.
// - limit sets highest accepted ring frequency within ten percent.
// - event after countdown reached zero rejects ring as too slow.
// - validation runs only while enable bit set, in normal and low-power mode.
// - ring valid only after meeting tolerances for whole confirmation interval.
module ring_frequency_validator #(
    parameter int TICK_DIV = ring_pkg::TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ring_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ring_event_i,
    output logic ring_valid_o
);
    // ****************************************************************
    // register bus
    // ****************************************************************
    ring_pkg::ctrl_a_t ctrl_a_q;
    ring_pkg::ctrl_b_t ctrl_b_q;
    ring_pkg::ctrl_c_t ctrl_c_q;
    ring_pkg::status_t status_q;
    ring_pkg::state_t state_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic req;
    logic wr_lane0;
    logic [ring_pkg::IDX_W-1:0] idx;
    logic clr_high;
    logic clr_low;

    assign req = wb_cyc_i && wb_stb_i;
    assign idx = wb_adr_i[ring_pkg::ADR_W-1:2];
    // writes land on the acknowledged edge only
    assign wr_lane0 = req && ack_q && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= '0;
        end else if (req && !ack_q) begin
            case (idx)
                ring_pkg::IDX_CTRL_A: dat_q <= {24'h000000, ctrl_a_q};
                ring_pkg::IDX_CTRL_B: dat_q <= {24'h000000, ctrl_b_q};
                ring_pkg::IDX_CTRL_C: dat_q <= {24'h000000, ctrl_c_q.ring_validation_enable,
                                                1'b0, ctrl_c_q.assert_time};
                ring_pkg::IDX_STATUS: dat_q <= {24'h000000, status_q};
                default: dat_q <= '0;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_a_q <= ring_pkg::RST_CTRL_A;
        end else if (wr_lane0 && idx == ring_pkg::IDX_CTRL_A) begin
            ctrl_a_q <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_b_q <= ring_pkg::RST_CTRL_B;
        end else if (wr_lane0 && idx == ring_pkg::IDX_CTRL_B) begin
            ctrl_b_q <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_c_q <= ring_pkg::RST_CTRL_C;
        end else if (wr_lane0 && idx == ring_pkg::IDX_CTRL_C) begin
            ctrl_c_q <= wb_dat_i[7:0];
        end
    end

    assign clr_high = wr_lane0 && idx == ring_pkg::IDX_STATUS && wb_dat_i[1];
    assign clr_low = wr_lane0 && idx == ring_pkg::IDX_STATUS && wb_dat_i[2];

    // ****************************************************************
    // timebase and countdown
    // ****************************************************************
    logic en;
    logic tick;
    logic ev;
    logic [5:0] timer_q;
    logic [ring_pkg::PHASE_W-1:0] phase_q;
    logic [ring_pkg::PHASE_W-1:0] phase_nx;
    logic [ring_pkg::PHASE_W-1:0] conf_target;
    logic [ring_pkg::PHASE_W-1:0] dly_target;
    logic [2:0] dly_code;
    logic too_high;
    logic too_low;
    logic fault;
    logic conf_done;
    logic dly_done;

    // no mode input: low-power mode changes nothing here
    assign en = ctrl_c_q.ring_validation_enable;
    assign ev = en && ring_event_i;

    ring_tick_gen #(
        .DIV(TICK_DIV)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(en),
        .tick_o(tick)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            timer_q <= '0;
        end else if (ev) begin
            timer_q <= ctrl_c_q.assert_time;
        end else if (tick && timer_q != '0) begin
            timer_q <= timer_q - 6'h01;
        end
    end

    // remaining count tells how soon the event came
    assign too_high = ev && state_q != ring_pkg::ST_IDLE
                      && timer_q > ctrl_a_q.max_ring_freq_limit;
    assign too_low = ev && state_q != ring_pkg::ST_IDLE && timer_q == '0;
    assign fault = too_high || too_low;

    assign dly_code = {ctrl_b_q.delay_hi, ctrl_a_q.delay_lo};
    assign conf_target = ring_pkg::confirm_ticks(ctrl_b_q.ring_confirm_interval);
    assign dly_target = ring_pkg::delay_ticks(dly_code);
    assign phase_nx = phase_q + ring_pkg::PHASE_W'(1);
    assign conf_done = state_q == ring_pkg::ST_QUALIFY && tick && phase_nx == conf_target;
    assign dly_done = state_q == ring_pkg::ST_DELAY && tick && phase_nx == dly_target;

    // ****************************************************************
    // qualification sequence
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            state_q <= ring_pkg::ST_IDLE;
        end else begin
            case (state_q)
                ring_pkg::ST_IDLE: begin
                    if (ev) begin
                        state_q <= ring_pkg::ST_QUALIFY;
                    end
                end
                ring_pkg::ST_QUALIFY: begin
                    if (!fault && conf_done) begin
                        state_q <= (dly_code == 3'h0) ? ring_pkg::ST_VALID : ring_pkg::ST_DELAY;
                    end
                end
                ring_pkg::ST_DELAY: begin
                    if (fault) begin
                        state_q <= ring_pkg::ST_QUALIFY;
                    end else if (dly_done) begin
                        state_q <= ring_pkg::ST_VALID;
                    end
                end
                ring_pkg::ST_VALID: begin
                    // no ring-end timeout here, only a bad event, a cleared enable bit or reset exits
                    if (fault) begin
                        state_q <= ring_pkg::ST_QUALIFY;
                    end
                end
                default: state_q <= ring_pkg::ST_IDLE;
            endcase
        end
    end

    // a rejected event restarts the interval from that event
    always_ff @(posedge clk_i) begin
        if (rst_i || !en || fault || state_q == ring_pkg::ST_IDLE
            || conf_done || dly_done) begin
            phase_q <= '0;
        end else if (tick) begin
            phase_q <= phase_nx;
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= '0;
        end else begin
            status_q.ring_valid <= en && state_q == ring_pkg::ST_VALID && !fault;
            status_q.too_high <= too_high || (status_q.too_high && !clr_high);
            status_q.too_low <= too_low || (status_q.too_low && !clr_low);
        end
    end

    assign ring_valid_o = status_q.ring_valid;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_confirmed;
        state_q == ring_pkg::ST_QUALIFY && conf_done && !fault;
    endsequence

    sequence seq_delay_over;
        state_q == ring_pkg::ST_DELAY && dly_done && !fault;
    endsequence

    AST_RESET_CTRL_A: assert property ($fell(rst_i) |-> ctrl_a_q == ring_pkg::RST_CTRL_A)
        else $error("control word not at reset value");
    AST_ZERO_DELAY: assert property (seq_confirmed ##0 dly_code == 3'h0 |=>
        state_q == ring_pkg::ST_VALID ##1 (ring_valid_o || $past(fault) || !$past(en)))
        else $error("zero delay did not validate at once");
    AST_DELAY_END: assert property (seq_delay_over |=> state_q == ring_pkg::ST_VALID)
        else $error("delay end did not validate");
    AST_DELAY_LEN: assert property ($rose(state_q == ring_pkg::ST_DELAY) |->
        phase_q == '0)
        else $error("delay phase not restarted");
    AST_TIMER_LOAD: assert property (ev |=> timer_q == $past(ctrl_c_q.assert_time))
        else $error("timer not loaded on event");
    AST_TIMER_DEC: assert property (en && !ev && tick && timer_q != '0 ##1 en |->
        timer_q == $past(timer_q) - 6'h01)
        else $error("timer did not count down");
    AST_TOO_FAST: assert property (too_high |=> status_q.too_high
        && state_q == ring_pkg::ST_QUALIFY && !ring_valid_o)
        else $error("fast ring not rejected");
    AST_TOO_SLOW: assert property (ev && state_q != ring_pkg::ST_IDLE && timer_q == '0 |=>
        status_q.too_low && !ring_valid_o)
        else $error("slow ring not rejected");
    AST_DISABLED: assert property (!en |=> state_q == ring_pkg::ST_IDLE
        ##1 !ring_valid_o)
        else $error("validation ran while disabled");
    AST_CONFIRM: assert property (seq_confirmed |=> state_q != ring_pkg::ST_QUALIFY)
        else $error("confirmation interval not honoured");
    AST_TICK_GAP: assert property (tick |=> !tick [*2])
        else $error("tick pulses too close");
    AST_WB_ACK: assert property (req && !ack_q |=> ack_q ##1 !ack_q)
        else $error("bus answer not a single cycle");

endmodule

// *** tb/ring_line_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// line threshold detector stand-in
// ****************************************************************
// one-cycle event pulse every gap_i cycles while run_i is high;
// first pulse comes at once so a burst starts a qualification
module ring_line_model (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [11:0] gap_i,
    output logic ring_event_o
);
    logic [11:0] cnt_q;

    always @(posedge clk_i) begin
        if (!run_i) begin
            cnt_q <= 12'h000;
            ring_event_o <= 1'b0;
        end else if (cnt_q == 12'h000) begin
            ring_event_o <= 1'b1;
            cnt_q <= gap_i - 12'h001;
        end else begin
            ring_event_o <= 1'b0;
            cnt_q <= cnt_q - 12'h001;
        end
    end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    // ****************************************************************
    // signals
    // ****************************************************************
    // tick shortened to 8 cycles: one 2 ms step is 8 clocks here
    localparam int DIV = 8;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic ring_event_i, ring_valid_o, run_q;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [11:0] gap_q;
    int mismatches, total_checks;

    ring_frequency_validator #(.TICK_DIV(DIV)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ring_event_i(ring_event_i), .ring_valid_o(ring_valid_o));

    ring_line_model line (.clk_i(clk_i), .run_i(run_q), .gap_i(gap_q),
        .ring_event_o(ring_event_i));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    // no fixed latency assumed: wait for ack under a bound
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(what, exp, q);
    endtask

    task automatic burst(input logic [11:0] gap);
        @(posedge clk_i);
        run_q <= 1'b0;
        @(posedge clk_i);
        gap_q <= gap;
        run_q <= 1'b1;
    endtask

    task automatic stop();
        @(posedge clk_i);
        run_q <= 1'b0;
    endtask

    task automatic vchk(input int n, input logic exp);
        repeat (n) @(posedge clk_i);
        chk("ring_valid_o", {31'h0, exp}, {31'h0, ring_valid_o});
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        mismatches = 0;
        total_checks = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, run_q} = 4'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h0;
        gap_q = 12'h018;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h58, 32'h96, "ctrl_a");
        rd(8'h5c, 32'h2d, "ctrl_b");
        rd(8'h60, 32'h19, "ctrl_c");
        rd(8'h64, 32'h0, "status");
        wr(8'h00, 32'h55);
        rd(8'h00, 32'h0, "unmapped");
        wr(8'h58, 32'h4a);
        rd(8'h58, 32'h4a, "ctrl_a");
        // lane 0 not enabled: the write must be ignored
        wb_sel_i <= 4'h0;
        wr(8'h58, 32'hff);
        wb_sel_i <= 4'h1;
        rd(8'h58, 32'h4a, "ctrl_a_no_lane");
        // limit 10 for assertion 20: shortest spacing 10 steps plus one of slack
        wr(8'h58, 32'h0a);
        wr(8'h5c, 32'h0);
        wr(8'h60, 32'h54);
        rd(8'h60, 32'h14, "ctrl_c");
        // fast events while disabled must leave no trace
        burst(12'd24);
        vchk(400, 1'b0);
        stop();
        rd(8'h64, 32'h0, "status");
        // 15-step spacing: inside the window, valid after 50 steps
        wr(8'h60, 32'h94);
        burst(12'd120);
        vchk(300, 1'b0);
        vchk(420, 1'b1);
        rd(8'h64, 32'h1, "status");
        // 3-step spacing leaves count above limit
        burst(12'd24);
        vchk(100, 1'b0);
        stop();
        rd(8'h64, 32'h2, "status");
        wr(8'h64, 32'h07);
        rd(8'h64, 32'h0, "status");
        // back to idle, else the first slow event is judged against an old count
        wr(8'h60, 32'h14);
        wr(8'h60, 32'h94);
        // 25-step spacing lets the countdown run out
        burst(12'd200);
        vchk(500, 1'b0);
        stop();
        rd(8'h64, 32'h4, "status");
        wr(8'h64, 32'h07);
        // delay code 001: 50 confirm steps then 128 delay steps
        wr(8'h60, 32'h14);
        wr(8'h58, 32'h4a);
        wr(8'h60, 32'h94);
        burst(12'd120);
        vchk(1300, 1'b0);
        vchk(300, 1'b1);
        stop();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end
endmodule
